// ===== logic/pfd_defs.svh
// Summary of operation
// - Quadrature mode: four counts per cycle
// - Quadrature counts both edges of A, B
// - Pulse mode: one channel, one count/cycle
// - High valid: capture while input 24 high
// - Low valid: capture while input 24 low
// - Match mode: two equal reads, ignore 24
// - Gray mode: decode gray, ignore 24
// - Word width never below eight bits
// - Match or gray width at most 16
// - Valid-line modes allow up to 23 bits
// - Unsigned interpretation by default
// - Signed option: zero at travel centre
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH
`define PFD_IN_W 24
`define PFD_VALID_BIT 23
`define PFD_MIN_BITS 5'h08
`define PFD_MAX_BITS_QUAL 5'h10
`define PFD_MAX_BITS_VALID 5'h17
`define PFD_CNT_W 32
`define PFD_CNT_RESET 32'h00000000
`define PFD_POS_RESET 24'h000000
`define PFD_SETTLE_CYCLES 2'h3
`endif

// ===== logic/pfd_pkg.sv
package pfd_pkg;
   typedef enum logic {
      PFD_ENC_QUAD = 1'b0,
      PFD_ENC_PULSE = 1'b1
   } pfd_enc_mode_t;
   typedef enum logic [1:0] {
      PFD_QUAL_HIGH = 2'b00,
      PFD_QUAL_LOW = 2'b01,
      PFD_QUAL_SAME = 2'b10,
      PFD_QUAL_GRAY = 2'b11
   } pfd_qual_t;
endpackage : pfd_pkg

// ===== logic/pfd_word_if.sv
`timescale 1ns/100ps
interface pfd_word_if;
   logic [23:0] raw;
   logic [23:0] word;
   logic take;
   modport qual (input raw, output word, output take);
   modport top (output raw, input word, input take);
endinterface : pfd_word_if

// ===== logic/pfd_word_qualifier.sv
`timescale 1ns/100ps
`include "pfd_defs.svh"
module pfd_word_qualifier (
   input wire logic clk,
   input wire logic reset_n,
   input wire pfd_pkg::pfd_qual_t qualMode,
   input wire logic [4:0] numBits,
   pfd_word_if.qual wordBus
);
   import pfd_pkg::*;
   logic [23:0] prevRaw;
   logic [23:0] mask;
   logic [23:0] masked;
   logic [23:0] grayBin;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prevRaw <= `PFD_POS_RESET;
      end else begin
         prevRaw <= wordBus.raw;
      end
   end

   always_comb begin
      mask = ~(24'hFFFFFF << numBits);
      mask[`PFD_VALID_BIT] = 1'b0;
      masked = wordBus.raw & mask;
      grayBin[23] = masked[23];
      for (int i = 22; i >= 0; i--) begin
         grayBin[i] = grayBin[i + 1] ^ masked[i];
      end
   end

   always_comb begin
      wordBus.word = masked;
      wordBus.take = 1'b0;
      unique case (qualMode)
         PFD_QUAL_HIGH: wordBus.take = wordBus.raw[`PFD_VALID_BIT];
         PFD_QUAL_LOW: wordBus.take = !wordBus.raw[`PFD_VALID_BIT];
         PFD_QUAL_SAME: wordBus.take = (wordBus.raw & mask) == (prevRaw & mask);
         PFD_QUAL_GRAY: begin
            wordBus.word = grayBin;
            wordBus.take = 1'b1;
         end
      endcase
   end

   sameTake_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_SAME && wordBus.take) |-> ((wordBus.raw & mask) == ($past(wordBus.raw) & mask)))
      else $error("match mode took unequal reads");
endmodule : pfd_word_qualifier

// ===== logic/position_feedback_decoder.sv
`timescale 1ns/100ps
`include "pfd_defs.svh"
module position_feedback_decoder (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic encA,
   input wire logic encB,
   input wire pfd_pkg::pfd_enc_mode_t encMode,
   input wire logic pulseUseB,
   input wire logic [23:0] ttlIn,
   input wire pfd_pkg::pfd_qual_t qualMode,
   input wire logic [4:0] dataBits,
   input wire logic signedWord,
   output logic [31:0] encCount,
   output logic [31:0] absPosition,
   output logic absUpdated
);
   import pfd_pkg::*;
   logic [1:0] syncA;
   logic [1:0] syncB;
   logic prevA;
   logic prevB;
   logic [23:0] ttlMeta;
   logic [23:0] ttlSync;
   logic [4:0] numBits;
   logic [23:0] heldWord;
   logic [4:0] heldBits;
   logic heldSigned;
   logic edgeA;
   logic edgeB;
   logic [31:0] next_encCount;
   logic [1:0] settleCnt;
   logic settled;
   logic accept;
   pfd_word_if wordBus ();

   // Pins cross in by two flip-flops; first stage is read only by the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= 2'h0;
         syncB <= 2'h0;
         prevA <= 1'b0;
         prevB <= 1'b0;
      end else begin
         syncA <= {syncA[0], encA};
         syncB <= {syncB[0], encB};
         prevA <= syncA[1];
         prevB <= syncB[1];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ttlMeta <= `PFD_POS_RESET;
         ttlSync <= `PFD_POS_RESET;
      end else begin
         ttlMeta <= ttlIn;
         ttlSync <= ttlMeta;
      end
   end

   // Pin history is not trusted until both sync stages and the edge register
   // have filled; otherwise a pin idling high would count once after reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         settleCnt <= 2'h0;
      end else if (settleCnt != `PFD_SETTLE_CYCLES) begin
         settleCnt <= settleCnt + 2'h1;
      end
   end

   assign settled = (settleCnt == `PFD_SETTLE_CYCLES);
   assign edgeA = settled && (syncA[1] ^ prevA);
   assign edgeB = settled && (syncB[1] ^ prevB);

   always_comb begin
      next_encCount = encCount;
      unique case (encMode)
         PFD_ENC_QUAD: begin
            // Direction from the standard A/B phase relation
            if (edgeA && !edgeB) begin
               next_encCount = (syncA[1] ^ syncB[1]) ? encCount - 32'h1 : encCount + 32'h1;
            end else if (edgeB && !edgeA) begin
               next_encCount = (syncA[1] ^ syncB[1]) ? encCount + 32'h1 : encCount - 32'h1;
            end
         end
         PFD_ENC_PULSE: begin
            // Rising edge only on the selected channel
            if (pulseUseB ? (edgeB && syncB[1]) : (edgeA && syncA[1])) begin
               next_encCount = encCount + 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         encCount <= `PFD_CNT_RESET;
      end else begin
         encCount <= next_encCount;
      end
   end

   // Out-of-range width settings are clamped rather than rejected
   always_comb begin
      numBits = dataBits;
      if (numBits < `PFD_MIN_BITS) begin
         numBits = `PFD_MIN_BITS;
      end
      if ((qualMode == PFD_QUAL_SAME || qualMode == PFD_QUAL_GRAY) && numBits > `PFD_MAX_BITS_QUAL) begin
         numBits = `PFD_MAX_BITS_QUAL;
      end else if (numBits > `PFD_MAX_BITS_VALID) begin
         numBits = `PFD_MAX_BITS_VALID;
      end
   end

   assign wordBus.raw = ttlSync;

   pfd_word_qualifier u_qual (
      .clk(clk),
      .reset_n(reset_n),
      .qualMode(qualMode),
      .numBits(numBits),
      .wordBus(wordBus)
   );

   // Sync stages still holding reset values must not pass as a word
   assign accept = settled && wordBus.take;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         heldWord <= `PFD_POS_RESET;
         heldBits <= `PFD_MIN_BITS;
         heldSigned <= 1'b0;
         absUpdated <= 1'b0;
      end else begin
         absUpdated <= accept;
         if (accept) begin
            heldWord <= wordBus.word;
            heldBits <= numBits;
            heldSigned <= signedWord;
         end
      end
   end

   // Sign extend from the top data bit when signed, else zero extend
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         absPosition <= 32'h00000000;
      end else if (heldSigned && heldWord[heldBits - 5'h1]) begin
         absPosition <= {8'h00, heldWord} | (32'hFFFFFFFF << heldBits);
      end else begin
         absPosition <= {8'h00, heldWord};
      end
   end

   quadStep_a: assert property (@(posedge clk) disable iff (!reset_n)
      (encMode == PFD_ENC_QUAD && (edgeA ^ edgeB)) |=> (encCount - $past(encCount) == 32'h1
      || $past(encCount) - encCount == 32'h1))
      else $error("quadrature edge did not move count by one");
   pulseOne_a: assert property (@(posedge clk) disable iff (!reset_n)
      (encMode == PFD_ENC_PULSE && !(pulseUseB ? (edgeB && syncB[1]) : (edgeA && syncA[1])))
      |=> encCount == $past(encCount))
      else $error("pulse count moved without rising edge");
   highTake_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_HIGH && !ttlSync[`PFD_VALID_BIT]) |=> !absUpdated)
      else $error("captured while valid low");
   lowTake_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_LOW && ttlSync[`PFD_VALID_BIT]) |=> !absUpdated)
      else $error("captured while valid high");
   widthRange_a: assert property (@(posedge clk) disable iff (!reset_n)
      numBits >= `PFD_MIN_BITS && numBits <= `PFD_MAX_BITS_VALID)
      else $error("width out of range");
   qualWidth_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_SAME || qualMode == PFD_QUAL_GRAY) |-> numBits <= `PFD_MAX_BITS_QUAL)
      else $error("match or gray width above 16");
   maskHigh_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wordBus.word >> numBits) == 24'h000000)
      else $error("bits above width reach position");
   holdPos_a: assert property (@(posedge clk) disable iff (!reset_n)
      !wordBus.take |=> $stable(heldWord))
      else $error("position changed without accepted word");
   posHold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !absUpdated |=> $stable(absPosition))
      else $error("position moved without update mark");
   settleHold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !settled |=> !absUpdated && $stable(encCount))
      else $error("reaction before sync stages filled");
   quadBoth_a: assert property (@(posedge clk) disable iff (!reset_n)
      (encMode == PFD_ENC_QUAD && edgeA && edgeB) |=> $stable(encCount))
      else $error("simultaneous edges moved the count");
   highAccept_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_HIGH && ttlSync[`PFD_VALID_BIT] && settled) |=> absUpdated)
      else $error("word not taken while valid high");
   lowAccept_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_LOW && !ttlSync[`PFD_VALID_BIT] && settled) |=> absUpdated)
      else $error("word not taken while valid low");
   pulseRise_a: assert property (@(posedge clk) disable iff (!reset_n)
      (encMode == PFD_ENC_PULSE && (pulseUseB ? (edgeB && syncB[1]) : (edgeA && syncA[1])))
      |=> encCount == $past(encCount) + 32'h1)
      else $error("pulse rising edge not counted");
   validWidth_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_HIGH || qualMode == PFD_QUAL_LOW) && dataBits >= `PFD_MAX_BITS_VALID
      |-> numBits == `PFD_MAX_BITS_VALID)
      else $error("valid-line width not opened to 23");
   grayTake_a: assert property (@(posedge clk) disable iff (!reset_n)
      (qualMode == PFD_QUAL_GRAY && settled) |=> absUpdated)
      else $error("gray word not taken");
   // A taken word first shows as the update mark, then as the position
   sequence plainTaken_s;
      accept && !signedWord;
   endsequence
   sequence signTaken_s;
      accept && signedWord && wordBus.word[numBits - 5'h1];
   endsequence
   sequence markShown_s;
      absUpdated;
   endsequence
   plainShow_a: assert property (@(posedge clk) disable iff (!reset_n)
      plainTaken_s ##1 markShown_s |=> absPosition == {8'h00, $past(wordBus.word, 2)})
      else $error("unsigned word not shown as position");
   signShow_a: assert property (@(posedge clk) disable iff (!reset_n)
      signTaken_s ##1 markShown_s |=> (~absPosition >> $past(numBits, 2)) == 32'h00000000)
      else $error("signed word not extended");
endmodule : position_feedback_decoder

// ===== tb/pfd_feed_model.sv
`timescale 1ns/100ps
module pfd_feed_model (
   input wire logic clk,
   output logic encA,
   output logic encB,
   output logic [23:0] ttlIn
);
   initial begin
      encA = 1'b0;
      encB = 1'b0;
      ttlIn = 24'h000000;
   end
   // One full encoder cycle; 4 clocks a level clears the 3-clock sync
   task automatic cycle(input logic rev);
      logic [7:0] s;
      s = rev ? 8'h78 : 8'hB4;
      for (int i = 0; i < 4; i++) begin
         repeat (4) @(posedge clk);
         #1 {encA, encB} = s[7 - 2 * i -: 2];
      end
   endtask : cycle
   // Both channels flipping at once is illegal and must leave the count alone
   task automatic jump;
      repeat (4) @(posedge clk);
      #1 {encA, encB} = ~{encA, encB};
   endtask : jump
   // Word stays still while the valid line is asserted
   task automatic present(input logic [22:0] w, input logic lvl, input logic churn);
      @(posedge clk);
      #1 ttlIn = {~lvl, ~w};
      @(posedge clk);
      #1 ttlIn = {lvl, w};
      repeat (8) @(posedge clk);
      // Released lines show garbage, not the old word
      if (churn) #1 ttlIn = {~lvl, ~w};
   endtask : present
endmodule : pfd_feed_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   import pfd_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic encA, encB, pulseUseB, signedWord, absUpdated;
   pfd_enc_mode_t encMode;
   pfd_qual_t qualMode;
   logic [4:0] dataBits;
   logic [23:0] ttlIn;
   logic [31:0] encCount, absPosition, start, want;
   logic [22:0] w, raw;
   int bits;
   int mismatches = 0;
   int comparisons = 0;
   always #4 clk = ~clk;
   pfd_feed_model pfd_feed_model_i (.clk(clk), .encA(encA), .encB(encB), .ttlIn(ttlIn));
   position_feedback_decoder position_feedback_decoder_i (.clk(clk), .reset_n(reset_n),
      .encA(encA), .encB(encB), .encMode(encMode), .pulseUseB(pulseUseB), .ttlIn(ttlIn),
      .qualMode(qualMode), .dataBits(dataBits), .signedWord(signedWord),
      .encCount(encCount), .absPosition(absPosition), .absUpdated(absUpdated));
   function automatic logic [31:0] mag(input logic [31:0] d);
      mag = d[31] ? -d : d;
   endfunction : mag
   function automatic logic [31:0] expectPos(input logic [22:0] v, input int n, input logic sgn);
      logic [31:0] m;
      m = (32'h1 << n) - 32'h1;
      expectPos = {9'h000, v} & m;
      if (sgn && expectPos[n - 1]) expectPos = expectPos | ~m;
   endfunction : expectPos
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // Whole run is under 1000 cycles; this margin only catches a hang
   initial begin
      #40000;
      mismatches++;
      conclude();
   end
   initial begin
      encMode = PFD_ENC_QUAD;
      pulseUseB = 1'b0;
      qualMode = PFD_QUAL_HIGH;
      dataBits = 5'h0C;
      signedWord = 1'b0;
      void'($urandom(70));
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      @(posedge clk);
      check(encCount, 32'h00000000);
      check(absPosition, 32'h00000000);
      start = encCount;
      pfd_feed_model_i.cycle(1'b0);
      repeat (6) @(posedge clk);
      check(mag(encCount - start), 32'h00000004);
      pfd_feed_model_i.cycle(1'b1);
      repeat (6) @(posedge clk);
      check(encCount, start);
      // Corner case: both channels flip together, out and back
      pfd_feed_model_i.jump();
      pfd_feed_model_i.jump();
      repeat (6) @(posedge clk);
      #1;
      check(encCount, start);
      $display("quadrature test done");
      encMode = PFD_ENC_PULSE;
      for (int c = 0; c < 2; c++) begin
         pulseUseB = c[0];
         start = encCount;
         pfd_feed_model_i.cycle(1'b0);
         repeat (6) @(posedge clk);
         #1;
         check(mag(encCount - start), 32'h00000001);
      end
      $display("pulse test done");
      for (int m = 0; m < 4; m++) begin
         qualMode = pfd_qual_t'(m);
         for (int k = 0; k < 4; k++) begin
            bits = (k == 0) ? ((m > 1) ? 16 : 23) : (k == 1) ? 8 : 8 + $urandom_range(m > 1 ? 8 : 15);
            // Corner widths drive the clamp from above and below
            dataBits = (k == 0) ? 5'h1F : (k == 1) ? 5'h03 : 5'(bits);
            signedWord = (k == 3);
            w = 23'($urandom);
            if (k == 3) w[bits - 1] = 1'b1;
            raw = w;
            if (m == 3) begin
               w = w & ((23'h1 << bits) - 23'h1);
               raw = w ^ (w >> 1);
            end
            pfd_feed_model_i.present(raw, (m == 1) ? 1'b0 : (m == 0) ? 1'b1 : 1'($urandom), m < 2);
            repeat (6) @(posedge clk);
            #1;
            want = expectPos(w, bits, signedWord);
            check(absPosition, want);
            if (m < 2) check({31'h0, absUpdated}, 32'h00000000);
            else check({31'h0, absUpdated}, 32'h00000001);
         end
         $display("parallel word mode %0d done", m);
      end
      conclude();
   end
endmodule : testbench
